/* File: verif/pin_source.sv */
// partner model: external digital sources driving the eight port pins
`timescale 1ns/10ps
module pin_source (
	input wire logic pclk, // system clock, used only to pace changes
	output logic [7:0] port_pin // pin levels seen by the block
);
	initial begin
		port_pin = 8'h00;
	end

	// levels are held for many cycles so no pulse is shorter than a clock
	task automatic set_pins(input logic [7:0] v);
		@(posedge pclk);
		port_pin <= v;
		repeat (6) @(posedge pclk);
	endtask
endmodule

/* File: verif/port_pin_change_interrupt_test.sv */
// testbench: pin change block driven over APB and from the pin model
`timescale 1ns/10ps
module port_pin_change_interrupt_test;
	import pin_change_pkg::*;
	logic pclk;
	logic presetn;
	logic sleep_active;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	logic [7:0] port_pin;
	logic irq;
	logic wake;
	logic change_summary_flag;
	int n_mismatch;
	int checked;
	logic [31:0] rd;
	logic err;
	logic [3:0] strb;

	pin_source i_pin_source (.pclk(pclk), .port_pin(port_pin));

	port_pin_change_interrupt i_port_pin_change_interrupt (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.port_pin(port_pin), .sleep_active(sleep_active), .irq(irq), .wake(wake),
		.change_summary_flag(change_summary_flag));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		apb_req.paddr <= a;
		apb_req.pwrite <= wr;
		apb_req.pwdata <= wd;
		apb_req.pstrb <= strb;
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			$display("[FAIL] %0t no bus answer", $time);
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_chk(RISE_EN_OFFSET, 32'h0);
		rd_chk(FALL_EN_OFFSET, 32'h0);
		rd_chk(FLAGS_OFFSET, 32'h0);
		rd_chk(CONTROL_OFFSET, 32'h0);
		chk({irq, wake, change_summary_flag}, 32'h0);
	endtask

	task automatic t_rise();
		apb(1'b1, RISE_EN_OFFSET, 32'h01);
		apb(1'b1, CONTROL_OFFSET, 32'h01);
		i_pin_source.set_pins(8'h01);
		rd_chk(FLAGS_OFFSET, 32'h01);
		chk({irq, change_summary_flag}, 32'h3);
		rd_chk(CONTROL_OFFSET, 32'h03);
		apb(1'b1, FLAGS_OFFSET, 32'h00);
		i_pin_source.set_pins(8'h00);
		rd_chk(FLAGS_OFFSET, 32'h00);
		chk(irq, 1'b0);
	endtask

	task automatic t_fall();
		apb(1'b1, FALL_EN_OFFSET, 32'h80);
		i_pin_source.set_pins(8'h80);
		rd_chk(FLAGS_OFFSET, 32'h00);
		i_pin_source.set_pins(8'h00);
		rd_chk(FLAGS_OFFSET, 32'h80);
		apb(1'b1, FLAGS_OFFSET, 32'h00);
		rd_chk(FLAGS_OFFSET, 32'h00);
		chk(change_summary_flag, 1'b0);
	endtask

	task automatic t_masked();
		apb(1'b1, CONTROL_OFFSET, 32'h00);
		i_pin_source.set_pins(8'h01);
		rd_chk(FLAGS_OFFSET, 32'h01);
		chk({irq, change_summary_flag}, 32'h1);
		apb(1'b1, FLAGS_OFFSET, 32'h00);
	endtask

	task automatic t_wake();
		apb(1'b1, RISE_EN_OFFSET, 32'hFF);
		apb(1'b1, CONTROL_OFFSET, 32'h01);
		@(posedge pclk);
		sleep_active <= 1'b1;
		i_pin_source.set_pins(8'h03);
		chk(wake, 1'b1);
		rd_chk(FLAGS_OFFSET, 32'h02);
		@(posedge pclk);
		sleep_active <= 1'b0;
		apb(1'b1, FLAGS_OFFSET, 32'h00);
	endtask

	task automatic t_unmapped();
		apb(1'b1, 12'h010, 32'hFF);
		chk(err, 1'b1);
		rd_chk(12'h010, 32'h0);
		chk(err, 1'b1);
		rd_chk(RISE_EN_OFFSET, 32'hFF);
	endtask

	// lane 0 strobe low drops the write; lane 0 alone is enough
	task automatic t_strobe();
		strb = 4'hE;
		apb(1'b1, RISE_EN_OFFSET, 32'h00);
		rd_chk(RISE_EN_OFFSET, 32'hFF);
		strb = 4'h1;
		apb(1'b1, RISE_EN_OFFSET, 32'h04);
		rd_chk(RISE_EN_OFFSET, 32'h04);
		strb = 4'hF;
	endtask

	// the clearing write's access edge meets the flag-set edge of pin 2
	task automatic t_edge_clear();
		fork
			i_pin_source.set_pins(8'h07);
			begin
				@(posedge pclk);
				apb(1'b1, FLAGS_OFFSET, 32'h00);
			end
		join
		rd_chk(FLAGS_OFFSET, 32'h04);
		apb(1'b1, FLAGS_OFFSET, 32'h00);
		rd_chk(FLAGS_OFFSET, 32'h00);
	endtask

	// ----------------------------------------------------------------
	// clock, reset, sequence, verdict
	// ----------------------------------------------------------------
	task automatic conclude();
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// the whole sequence needs well under 1000 cycles
	initial begin
		#200us;
		n_mismatch++;
		conclude();
	end

	initial begin
		n_mismatch = 0;
		checked = 0;
		apb_req = '0;
		sleep_active = 1'b0;
		strb = 4'hF;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rise();
		t_fall();
		t_masked();
		t_wake();
		t_unmapped();
		t_strobe();
		t_edge_clear();
		// second reset in mid-run, with pins 0, 1 and 2 held high across it
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		conclude();
	end
endmodule

/* File: verilog/pin_change_pkg.sv */
// package: register map, field layout and bus carriers for the pin change block
package pin_change_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_PINS = 8;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] RISE_EN_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] FALL_EN_OFFSET = 12'h004;
	localparam logic [ADDR_W-1:0] FLAGS_OFFSET = 12'h008;
	localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 12'h00C;

	// ----------------------------------------------------------------
	// irq_control_reg field positions; register and read data reset values
	// ----------------------------------------------------------------
	localparam int CTRL_IRQ_EN_BIT = 0;
	localparam int CTRL_SUMMARY_BIT = 1;
	localparam logic [NUM_PINS-1:0] PIN_REG_RESET = 8'h00;
	localparam logic CTRL_IRQ_EN_RESET = 1'b0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

	// synchroniser warm-up: edges counted only once the previous sample is real
	localparam logic [1:0] WARM_DONE = 2'h3;

	// ----------------------------------------------------------------
	// APB carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [DATA_W-1:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} pin_edge_t;

endpackage

/* File: verilog/pin_edge_detect.sv */
// single pin synchroniser and edge pulse generator
`timescale 1ns/10ps
module pin_edge_detect (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic pin_in, // raw port pin, asynchronous
	output pin_change_pkg::pin_edge_t edge_out // one-cycle rise and fall pulses
);
	import pin_change_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic [1:0] warm;
	} det_state_t;

	det_state_t st_reg;
	det_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.meta = pin_in;
		// meta feeds only the second stage
		st_next.sync = st_reg.meta;
		st_next.prev = st_reg.sync;
		if (st_reg.warm != WARM_DONE) begin
			st_next.warm = st_reg.warm + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// edge pulses
	// ----------------------------------------------------------------
	// no edge is reported until prev holds a real sample, so a pin that
	// is already high at reset release does not fake a rising edge
	always_comb begin
		edge_out.rise = (st_reg.warm == WARM_DONE) && st_reg.sync && !st_reg.prev;
		edge_out.fall = (st_reg.warm == WARM_DONE) && !st_reg.sync && st_reg.prev;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_RISE_FROM_PIN: assert property (
		edge_out.rise |-> ($past(pin_in, 2) && !$past(pin_in, 3)))
		else $error("rise pulse without a low to high pin change");

	AST_FALL_FROM_PIN: assert property (
		edge_out.fall |-> (!$past(pin_in, 2) && $past(pin_in, 3)))
		else $error("fall pulse without a high to low pin change");

	AST_PULSE_ONE_CYCLE: assert property (
		(edge_out.rise |=> !edge_out.rise) and (edge_out.fall |=> !edge_out.fall))
		else $error("edge pulse lasted more than one cycle");

endmodule

/* File: verilog/port_pin_change_interrupt.sv */
// pin change interrupt block: eight pins, edge enables, sticky flags, APB slave
`timescale 1ns/10ps
module port_pin_change_interrupt (
	input wire logic pclk, // system clock, 10 MHz
	input wire logic presetn, // async reset, active low
	input pin_change_pkg::apb_req_t apb_req, // APB request from master
	output pin_change_pkg::apb_rsp_t apb_rsp, // APB answer, registered
	input wire logic [pin_change_pkg::NUM_PINS-1:0] port_pin, // raw port pins
	input wire logic sleep_active, // core asleep, same clock domain
	output logic irq, // change interrupt request, level
	output logic wake, // wake request while asleep, level
	output logic change_summary_flag // OR of all pin flags
);
	import pin_change_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PINS-1:0] rise_edge_enable;
		logic [NUM_PINS-1:0] fall_edge_enable;
		logic [NUM_PINS-1:0] pin_change_flags;
		logic change_irq_enable;
		logic change_summary_flag;
		logic irq;
		logic wake;
		apb_rsp_t rsp;
	} blk_state_t;

	blk_state_t st_reg;
	blk_state_t st_next;

	pin_edge_t pin_edge [NUM_PINS];
	logic [NUM_PINS-1:0] rise_pulse;
	logic [NUM_PINS-1:0] fall_pulse;
	logic [NUM_PINS-1:0] edge_hit;
	logic apb_setup;
	logic apb_access;
	logic apb_write;
	logic addr_ok;
	logic [DATA_W-1:0] rd_value;

	// ----------------------------------------------------------------
	// per-pin edge detection
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			pin_edge_detect u_det (
				.pclk(pclk),
				.presetn(presetn),
				.pin_in(port_pin[gi]),
				.edge_out(pin_edge[gi])
			);
			assign rise_pulse[gi] = pin_edge[gi].rise;
			assign fall_pulse[gi] = pin_edge[gi].fall;

			// a pulse in a disarmed direction must leave a clear flag clear
			AST_RISE_DISARMED: assert property (@(posedge pclk) disable iff (!presetn)
				(rise_pulse[gi] && !st_reg.rise_edge_enable[gi] && !st_reg.pin_change_flags[gi]
					&& !(apb_write && apb_req.paddr == FLAGS_OFFSET))
				|=> !st_reg.pin_change_flags[gi])
				else $error("rising edge flagged with rise detection disarmed");

			AST_FALL_DISARMED: assert property (@(posedge pclk) disable iff (!presetn)
				(fall_pulse[gi] && !st_reg.fall_edge_enable[gi] && !st_reg.pin_change_flags[gi]
					&& !(apb_write && apb_req.paddr == FLAGS_OFFSET))
				|=> !st_reg.pin_change_flags[gi])
				else $error("falling edge flagged with fall detection disarmed");
		end
	endgenerate

	// both enables may be set together, so one pin can flag on either edge
	assign edge_hit = (rise_pulse & st_reg.rise_edge_enable)
		| (fall_pulse & st_reg.fall_edge_enable);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign apb_setup = apb_req.psel && !apb_req.penable;
	assign apb_access = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
	// only byte lane 0 carries register bits; other lanes are ignored
	assign apb_write = apb_access && apb_req.pwrite && apb_req.pstrb[0];

	always_comb begin
		addr_ok = 1'b1;
		rd_value = RDATA_RESET;
		if (apb_req.paddr == RISE_EN_OFFSET) begin
			rd_value[NUM_PINS-1:0] = st_reg.rise_edge_enable;
		end else if (apb_req.paddr == FALL_EN_OFFSET) begin
			rd_value[NUM_PINS-1:0] = st_reg.fall_edge_enable;
		end else if (apb_req.paddr == FLAGS_OFFSET) begin
			rd_value[NUM_PINS-1:0] = st_reg.pin_change_flags;
		end else if (apb_req.paddr == CONTROL_OFFSET) begin
			rd_value[CTRL_IRQ_EN_BIT] = st_reg.change_irq_enable;
			rd_value[CTRL_SUMMARY_BIT] = st_reg.change_summary_flag;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rsp.pready = 1'b0;
		// answer prepared in the setup cycle: every access takes zero waits.
		// read data is the value seen in setup, one cycle before completion
		if (apb_setup) begin
			st_next.rsp.pready = 1'b1;
			st_next.rsp.pslverr = !addr_ok;
			st_next.rsp.prdata = apb_req.pwrite ? RDATA_RESET : rd_value;
		end
		if (apb_write && addr_ok) begin
			if (apb_req.paddr == RISE_EN_OFFSET) begin
				st_next.rise_edge_enable = apb_req.pwdata[NUM_PINS-1:0];
			end else if (apb_req.paddr == FALL_EN_OFFSET) begin
				st_next.fall_edge_enable = apb_req.pwdata[NUM_PINS-1:0];
			end else if (apb_req.paddr == FLAGS_OFFSET) begin
				st_next.pin_change_flags = apb_req.pwdata[NUM_PINS-1:0];
			end else begin
				st_next.change_irq_enable = apb_req.pwdata[CTRL_IRQ_EN_BIT];
			end
		end
		// a fresh edge wins over a software clear of the same flag
		st_next.pin_change_flags = st_next.pin_change_flags | edge_hit;
		st_next.change_summary_flag = |st_next.pin_change_flags;
		st_next.irq = st_next.change_irq_enable && st_next.change_summary_flag;
		st_next.wake = sleep_active && st_next.irq;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.rise_edge_enable <= PIN_REG_RESET;
			st_reg.fall_edge_enable <= PIN_REG_RESET;
			st_reg.pin_change_flags <= PIN_REG_RESET;
			st_reg.change_irq_enable <= CTRL_IRQ_EN_RESET;
			st_reg.change_summary_flag <= 1'b0;
			st_reg.irq <= 1'b0;
			st_reg.wake <= 1'b0;
			st_reg.rsp <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp = st_reg.rsp;
	assign irq = st_reg.irq;
	assign wake = st_reg.wake;
	assign change_summary_flag = st_reg.change_summary_flag;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_flag_write_zero;
		apb_write && (apb_req.paddr == FLAGS_OFFSET) && (apb_req.pwdata[NUM_PINS-1:0] == 8'h00);
	endsequence

	sequence s_flags_cleared;
		##1 (st_reg.pin_change_flags == 8'h00) && !change_summary_flag;
	endsequence

	AST_RISE_ARMED: assert property (
		(|(rise_pulse & st_reg.rise_edge_enable))
		|=> ((st_reg.pin_change_flags & $past(rise_pulse & st_reg.rise_edge_enable))
			== $past(rise_pulse & st_reg.rise_edge_enable)))
		else $error("armed rising edge did not set its flag");

	AST_FALL_ARMED: assert property (
		(|(fall_pulse & st_reg.fall_edge_enable))
		|=> ((st_reg.pin_change_flags & $past(fall_pulse & st_reg.fall_edge_enable))
			== $past(fall_pulse & st_reg.fall_edge_enable)))
		else $error("armed falling edge did not set its flag");

	AST_FLAG_HAS_CAUSE: assert property (
		(|(st_reg.pin_change_flags & ~$past(st_reg.pin_change_flags)))
		|-> ($past(edge_hit) != 8'h00) || $past(apb_write && apb_req.paddr == FLAGS_OFFSET))
		else $error("flag set with no enabled edge and no write");

	AST_SUMMARY_ON_HIT: assert property (
		(edge_hit != 8'h00) |=> change_summary_flag)
		else $error("enabled edge did not raise the summary flag");

	AST_WRITE_ZERO_CLEARS: assert property (
		(s_flag_write_zero and (edge_hit == 8'h00)) |-> s_flags_cleared)
		else $error("writing zero did not clear the flags");

	AST_RESET_VALUES: assert property (
		!$past(presetn) |-> (st_reg.rise_edge_enable == 8'h00)
			&& (st_reg.fall_edge_enable == 8'h00) && (st_reg.pin_change_flags == 8'h00))
		else $error("register not zero after reset");

	AST_IRQ_GATED: assert property (
		(!st_reg.change_irq_enable && (edge_hit != 8'h00)
			&& !(apb_write && apb_req.paddr == CONTROL_OFFSET))
		|=> change_summary_flag && !irq)
		else $error("flag not set or request leaked with enable clear");

	AST_SUMMARY_TRACKS: assert property (
		(st_reg.pin_change_flags != 8'h00) |-> change_summary_flag ##1
		((st_reg.pin_change_flags == 8'h00) || change_summary_flag))
		else $error("summary flag does not follow pin flags");

	AST_EDGE_BEATS_CLEAR: assert property (
		(s_flag_write_zero and (edge_hit != 8'h00))
		|=> ((st_reg.pin_change_flags & $past(edge_hit)) == $past(edge_hit))
			&& (irq == st_reg.change_irq_enable))
		else $error("edge lost during a flag clear");

	AST_WAKE_ON_EDGE: assert property (
		(sleep_active && st_reg.change_irq_enable && (edge_hit != 8'h00)
			&& !(apb_write && apb_req.paddr == CONTROL_OFFSET))
		|=> wake && (st_reg.pin_change_flags != 8'h00))
		else $error("edge during sleep did not wake with flags set");

	AST_READY_ONE_CYCLE: assert property (
		apb_setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
		else $error("pready not a single cycle after setup");

	// ----------------------------------------------------------------
	// assertions: register writes and answers
	// ----------------------------------------------------------------
	// each write lands at its access edge; the register shows it one edge later
	sequence s_rise_en_write;
		apb_write && (apb_req.paddr == RISE_EN_OFFSET);
	endsequence

	sequence s_fall_en_write;
		apb_write && (apb_req.paddr == FALL_EN_OFFSET);
	endsequence

	sequence s_ctrl_write;
		apb_write && (apb_req.paddr == CONTROL_OFFSET);
	endsequence

	// read data is the register as it stood in the setup cycle
	sequence s_flag_read_setup;
		apb_setup && !apb_req.pwrite && (apb_req.paddr == FLAGS_OFFSET);
	endsequence

	AST_RISE_EN_LANDS: assert property (
		s_rise_en_write
		|=> (st_reg.rise_edge_enable == $past(apb_req.pwdata[NUM_PINS-1:0])))
		else $error("rise enable write did not land");

	AST_FALL_EN_LANDS: assert property (
		s_fall_en_write
		|=> (st_reg.fall_edge_enable == $past(apb_req.pwdata[NUM_PINS-1:0])))
		else $error("fall enable write did not land");

	AST_IRQ_EN_LANDS: assert property (
		s_ctrl_write
		|=> (st_reg.change_irq_enable == $past(apb_req.pwdata[CTRL_IRQ_EN_BIT])))
		else $error("interrupt enable write did not land");

	AST_FLAGS_READ_BACK: assert property (
		s_flag_read_setup
		|=> (apb_rsp.prdata[NUM_PINS-1:0] == $past(st_reg.pin_change_flags)))
		else $error("flag read returned a value other than the flags");

	AST_CTRL_READ_BACK: assert property (
		(apb_setup && !apb_req.pwrite && (apb_req.paddr == CONTROL_OFFSET))
		|=> (apb_rsp.prdata[CTRL_SUMMARY_BIT] == $past(change_summary_flag)))
		else $error("summary bit read back wrong");

	// without a flag write, a set flag can only stay set
	AST_FLAGS_STICKY: assert property (
		!(apb_write && (apb_req.paddr == FLAGS_OFFSET))
		|=> ((st_reg.pin_change_flags & $past(st_reg.pin_change_flags))
			== $past(st_reg.pin_change_flags)))
		else $error("pin flag cleared without a flag write");

	// a write whose lane 0 strobe is low must change nothing
	AST_LANE0_GUARD: assert property (
		(apb_access && apb_req.pwrite && !apb_req.pstrb[0])
		|=> $stable(st_reg.rise_edge_enable) && $stable(st_reg.fall_edge_enable)
			&& $stable(st_reg.change_irq_enable))
		else $error("write with lane 0 strobe low changed a register");

	AST_ERROR_ONLY_UNMAPPED: assert property (
		apb_setup |=> (apb_rsp.pslverr == !$past(addr_ok)))
		else $error("bus error does not match the address decode");

	// only the low eight bits of any register carry state
	AST_RDATA_UPPER_ZERO: assert property (
		apb_rsp.pready |-> (apb_rsp.prdata[DATA_W-1:NUM_PINS] == 24'h000000))
		else $error("read data has bits set above the pin field");

	AST_IRQ_NEEDS_ENABLE: assert property (
		irq |-> (st_reg.change_irq_enable && change_summary_flag))
		else $error("interrupt request without enable and flag");

	AST_NO_WAKE_AWAKE: assert property (
		!sleep_active |=> !wake)
		else $error("wake request raised while the core was awake");

endmodule
